//--- design/pie_entry.sv
// Purpose: interrupt entry and return logic with ahb-lite register access
// Assumes: single clock, pins synchronised here, one retiring instruction
// Notes:   hardware updates win over a same-cycle software write
// Operation
// - non-critical take saves resume address and state in non-critical pair
// - critical take saves resume address and state in critical pair
// - debug take, when debug enabled, saves into the debug pair
// - handler address joins vector prefix with the selected vector offset
// - handler runs in supervisor state from its first instruction
// - syndrome register written with cause bits only on takes that set a cause bit
// - shared vectors leave status bits set for the handler
// - disabled conditions never redirect execution
// - critical may nest in non-critical without touching its saved pair
// - debug may nest in critical or non-critical handlers
// - take order: save context, fetch vector, then run handler
// - each return restores from its own pair and resumes there
// - supervisor entered for instruction and external or internal causes
// - without cache, data cache operations other than block zeroing are no-operations
// - without cache, block zeroing raises an alignment interrupt
// - without cache, block invalidate is a privileged no-operation
// - unsupported device control register number raises illegal instruction
// - 16-bit instruction builds limit the bit-reversal mask to 16 bits
// - critical input taken when request low and critical enable set
// - external input taken when request low and external enable set
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`include "pie_params.svh"

module pie_entry #(
    parameter bit SHORT_INSN = 1'b0
) (
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              crit_req_n,
    input  wire logic              ext_req_n,
    input  wire logic              mchk_req_n,
    input  wire pie_pkg::pie_instr_t instr,
    input  wire pie_pkg::pie_exc_t   exc,
    output logic                   redirect,
    output logic [31:0]            redirect_addr,
    output logic                   supervisor,
    output logic                   busy,
    output logic [31:0]            brev_mask
);
    import pie_pkg::*;

    pie_state_t s_q;
    pie_state_t s_d;
    logic       hreadyout_q;

    // handler address: prefix high half, offset bits 15:4
    function automatic logic [31:0] vec_addr(input logic [31:0] pfx,
                                             input logic [31:0] off);
        vec_addr = {pfx[31:16], off[15:4], 4'h0};
    endfunction

    // vector offset window, shared by write and read decode
    function automatic logic is_vec(input logic [7:0] a);
        is_vec = (a[7:6] == 2'(`PIE_A_VEC_BASE >> 6));
    endfunction

    // new machine state on entry: supervisor, class enables dropped
    function automatic logic [31:0] entry_state(input logic [31:0] ms,
                                                input pie_class_t cl);
        logic [31:0] r;
        r = ms;
        r[`PIE_MS_PR] = 1'b0;
        r[`PIE_MS_EE] = 1'b0;
        if (cl != PIE_CL_NONCRIT) begin
            r[`PIE_MS_CE] = 1'b0;
            r[`PIE_MS_ME] = 1'b0;
        end
        if (cl == PIE_CL_DEBUG) begin
            r[`PIE_MS_DE] = 1'b0;
        end
        entry_state = r;
    endfunction

    logic        user_mode;
    logic        crit_pend;
    logic        ext_pend;
    logic        mchk_pend;
    logic        dbg_pend;
    logic        in_run;
    logic        ins_ok;
    logic        align_pend;
    logic        priv_pend;
    logic        ill_pend;
    logic        take;
    logic [3:0]  take_vec;
    pie_class_t  take_class;
    logic [31:0] take_synd;
    logic        ap_start;
    logic        wr_phase;
    logic [31:0] rd_word;

    always_comb begin
        user_mode  = s_q.mstate[`PIE_MS_PR];
        in_run     = (s_q.fsm == PIE_ST_RUN);
        ins_ok     = in_run && instr.valid;
        // gated by enable bits, else no redirect
        crit_pend  = !s_q.crit_n_sync[1]
                     && s_q.mstate[`PIE_MS_CE];
        ext_pend   = !s_q.ext_n_sync[1]
                     && s_q.mstate[`PIE_MS_EE];
        mchk_pend  = !s_q.mchk_n_sync[1]
                     && s_q.mstate[`PIE_MS_ME];
        dbg_pend   = exc.debug && s_q.dbg_en
                     && s_q.mstate[`PIE_MS_DE];
        align_pend = ins_ok && instr.op == PIE_OP_DC_ZERO;
        priv_pend  = ins_ok && user_mode
                     && (instr.op == PIE_OP_DC_INVAL
                         || instr.op == PIE_OP_RET_NC
                         || instr.op == PIE_OP_RET_CR
                         || instr.op == PIE_OP_RET_DB);
        ill_pend   = ins_ok && instr.op == PIE_OP_DCR
                     && instr.dcr_num >= `PIE_DCR_COUNT;

        // fixed priority, only the winner is taken
        take       = in_run;
        take_vec   = `PIE_V_EXT;
        take_class = PIE_CL_NONCRIT;
        take_synd  = `PIE_RST_WORD;
        if (dbg_pend) begin
            take_vec   = `PIE_V_DEBUG;
            take_class = PIE_CL_DEBUG;
        end else if (crit_pend) begin
            take_vec   = `PIE_V_CRIT;
            take_class = PIE_CL_CRIT;
        end else if (mchk_pend) begin
            take_vec   = `PIE_V_MCHK;
            take_class = PIE_CL_CRIT;
        end else if (exc.istore && in_run) begin
            take_vec   = `PIE_V_ISTORE;
        end else if (exc.dstore && in_run) begin
            take_vec   = `PIE_V_DSTORE;
            take_synd[`PIE_SY_ST] = exc.dstore_is_store;
        end else if (align_pend) begin
            take_vec   = `PIE_V_ALIGN;
            take_synd[`PIE_SY_ST] = 1'b1;
        end else if (priv_pend) begin
            take_vec   = `PIE_V_PROG;
            take_synd[`PIE_SY_PPR] = 1'b1;
        end else if (ill_pend) begin
            take_vec   = `PIE_V_PROG;
            take_synd[`PIE_SY_PIL] = 1'b1;
        end else if (!ext_pend) begin
            take       = 1'b0;
        end
        if (!in_run) begin
            take = 1'b0;
        end

        ap_start = hsel && hready && htrans[1];
        wr_phase = s_q.ap_sel && s_q.ap_write;
    end

    always_comb begin
        s_d = s_q;
        s_d.crit_n_sync = {s_q.crit_n_sync[1:0], crit_req_n};
        s_d.ext_n_sync  = {s_q.ext_n_sync[1:0], ext_req_n};
        s_d.mchk_n_sync = {s_q.mchk_n_sync[1:0], mchk_req_n};
        s_d.redirect    = 1'b0;
        s_d.brev_mask   = SHORT_INSN ? {16'h0000, instr.brev_mask[15:0]}
                                     : instr.brev_mask;

        // software write lands first so a same-cycle hardware update wins
        if (wr_phase) begin
            unique case (s_q.ap_addr)
                `PIE_A_MSTATE:   s_d.mstate   = hwdata;
                `PIE_A_NC_RET:   s_d.nc_ret   = hwdata;
                `PIE_A_NC_STATE: s_d.nc_state = hwdata;
                `PIE_A_CR_RET:   s_d.cr_ret   = hwdata;
                `PIE_A_CR_STATE: s_d.cr_state = hwdata;
                `PIE_A_DB_RET:   s_d.db_ret   = hwdata;
                `PIE_A_DB_STATE: s_d.db_state = hwdata;
                `PIE_A_PREFIX:   s_d.prefix   = hwdata;
                `PIE_A_SYNDROME: s_d.syndrome = hwdata;
                `PIE_A_CONFIG:   s_d.dbg_en   = hwdata[0];
                default: begin
                    if (is_vec(s_q.ap_addr)) begin
                        s_d.vec_off[s_q.ap_addr[5:2]] = hwdata;
                    end
                end
            endcase
        end

        unique case (s_q.fsm)
            PIE_ST_RUN: begin
                if (take) begin
                    // context saved first; fetch follows next cycle
                    unique case (take_class)
                        PIE_CL_DEBUG: begin
                            s_d.db_ret   = instr.pc;
                            s_d.db_state = s_q.mstate;
                        end
                        PIE_CL_CRIT: begin
                            s_d.cr_ret   = instr.pc;
                            s_d.cr_state = s_q.mstate;
                        end
                        default: begin
                            s_d.nc_ret   = instr.pc;
                            s_d.nc_state = s_q.mstate;
                        end
                    endcase
                    s_d.mstate = entry_state(s_q.mstate,
                                             take_class);
                    if (take_synd != `PIE_RST_WORD) begin
                        s_d.syndrome = take_synd;
                    end
                    s_d.last_vec      = take_vec;
                    s_d.last_class    = take_class;
                    s_d.redirect_addr = vec_addr(s_d.prefix,
                                        s_d.vec_off[take_vec]);
                    s_d.fsm           = PIE_ST_FETCH;
                end else if (ins_ok) begin
                    unique case (instr.op)
                        PIE_OP_RET_NC: begin
                            s_d.mstate        = s_q.nc_state;
                            s_d.redirect_addr = s_q.nc_ret;
                            s_d.redirect      = 1'b1;
                        end
                        PIE_OP_RET_CR: begin
                            s_d.mstate        = s_q.cr_state;
                            s_d.redirect_addr = s_q.cr_ret;
                            s_d.redirect      = 1'b1;
                        end
                        PIE_OP_RET_DB: begin
                            s_d.mstate        = s_q.db_state;
                            s_d.redirect_addr = s_q.db_ret;
                            s_d.redirect      = 1'b1;
                        end
                        // cache ops retire with no effect here
                        default: begin
                        end
                    endcase
                end
            end
            PIE_ST_FETCH: begin
                s_d.redirect = 1'b1;
                s_d.fsm      = PIE_ST_RUN;
            end
        endcase

        // read data taken from next state so a write just before is seen
        rd_word = `PIE_RST_WORD;
        unique case (haddr[7:0])
            `PIE_A_MSTATE:   rd_word = s_d.mstate;
            `PIE_A_NC_RET:   rd_word = s_d.nc_ret;
            `PIE_A_NC_STATE: rd_word = s_d.nc_state;
            `PIE_A_CR_RET:   rd_word = s_d.cr_ret;
            `PIE_A_CR_STATE: rd_word = s_d.cr_state;
            `PIE_A_DB_RET:   rd_word = s_d.db_ret;
            `PIE_A_DB_STATE: rd_word = s_d.db_state;
            `PIE_A_PREFIX:   rd_word = s_d.prefix;
            `PIE_A_SYNDROME: rd_word = s_d.syndrome;
            `PIE_A_CONFIG:   rd_word = {31'h0, s_d.dbg_en};
            `PIE_A_STATUS:   rd_word = {25'h0, s_d.fsm, s_d.last_class,
                                        s_d.last_vec};
            default: begin
                if (is_vec(haddr[7:0])) begin
                    rd_word = s_d.vec_off[haddr[5:2]];
                end
            end
        endcase

        if (hready) begin
            s_d.ap_sel   = ap_start;
            s_d.ap_write = hwrite;
            s_d.ap_addr  = haddr[7:0];
            if (ap_start && !hwrite) begin
                s_d.hrdata = rd_word;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_q             <= '0;
            s_q.fsm         <= PIE_ST_RUN;
            s_q.crit_n_sync <= 3'h7;
            s_q.ext_n_sync  <= 3'h7;
            s_q.mchk_n_sync <= 3'h7;
            s_q.mstate      <= `PIE_RST_MSTATE;
            s_q.last_class  <= PIE_CL_NONE;
            hreadyout_q     <= 1'b0;
        end else begin
            s_q             <= s_d;
            hreadyout_q     <= 1'b1;
        end
    end

    always_comb begin
        hrdata        = s_q.hrdata;
        hreadyout     = hreadyout_q;
        hresp         = 1'b0;
        redirect      = s_q.redirect;
        redirect_addr = s_q.redirect_addr;
        supervisor    = !s_q.mstate[`PIE_MS_PR];
        busy          = (s_q.fsm == PIE_ST_FETCH);
        brev_mask     = s_q.brev_mask;
    end

endmodule

//--- design/pie_params.svh
// Purpose: constants for the interrupt entry block
// Assumes: 32-bit data, byte offsets on an ahb-lite word bus
// Notes:   offsets are byte addresses inside the block
`ifndef PIE_PARAMS_SVH
`define PIE_PARAMS_SVH

`define PIE_A_MSTATE     8'h00
`define PIE_A_NC_RET     8'h04
`define PIE_A_NC_STATE   8'h08
`define PIE_A_CR_RET     8'h0c
`define PIE_A_CR_STATE   8'h10
`define PIE_A_DB_RET     8'h14
`define PIE_A_DB_STATE   8'h18
`define PIE_A_PREFIX     8'h1c
`define PIE_A_SYNDROME   8'h20
`define PIE_A_CONFIG     8'h24
`define PIE_A_STATUS     8'h28
`define PIE_A_VEC_BASE   8'h40

`define PIE_MS_DE        9
`define PIE_MS_ME        12
`define PIE_MS_PR        14
`define PIE_MS_EE        15
`define PIE_MS_CE        17

`define PIE_SY_PIL       27
`define PIE_SY_PPR       28
`define PIE_SY_ST        23

`define PIE_V_CRIT       4'h0
`define PIE_V_MCHK       4'h1
`define PIE_V_DSTORE     4'h2
`define PIE_V_ISTORE     4'h3
`define PIE_V_EXT        4'h4
`define PIE_V_ALIGN      4'h5
`define PIE_V_PROG       4'h6
`define PIE_V_DEBUG      4'hf

`define PIE_RST_MSTATE   32'h0000_0000
`define PIE_RST_WORD     32'h0000_0000
`define PIE_DCR_COUNT    10'h040

`endif

//--- design/pie_pkg.sv
// Purpose: types shared by the interrupt entry block
// Assumes: pie_params.svh holds the numbers
// Notes:   state of the top module is one packed struct
package pie_pkg;

    typedef enum logic [1:0] {
        PIE_CL_NONE,
        PIE_CL_NONCRIT,
        PIE_CL_CRIT,
        PIE_CL_DEBUG
    } pie_class_t;

    typedef enum logic [2:0] {
        PIE_OP_OTHER,
        PIE_OP_RET_NC,
        PIE_OP_RET_CR,
        PIE_OP_RET_DB,
        PIE_OP_DC_ZERO,
        PIE_OP_DC_INVAL,
        PIE_OP_DC_OTHER,
        PIE_OP_DCR
    } pie_op_t;

    typedef enum logic {
        PIE_ST_RUN,
        PIE_ST_FETCH
    } pie_fsm_t;

    // one instruction presented by the pipeline for retirement
    typedef struct packed {
        logic        valid;
        pie_op_t     op;
        logic [31:0] pc;
        logic [9:0]  dcr_num;
        logic [31:0] brev_mask;
    } pie_instr_t;

    // synchronous exception events from the pipeline, one-cycle pulses
    typedef struct packed {
        logic dstore;
        logic dstore_is_store;
        logic istore;
        logic debug;
    } pie_exc_t;

    typedef struct packed {
        pie_fsm_t         fsm;
        logic [2:0]       crit_n_sync;
        logic [2:0]       ext_n_sync;
        logic [2:0]       mchk_n_sync;
        logic             ap_sel;
        logic             ap_write;
        logic [7:0]       ap_addr;
        logic [31:0]      hrdata;
        logic [31:0]      mstate;
        logic [31:0]      nc_ret;
        logic [31:0]      nc_state;
        logic [31:0]      cr_ret;
        logic [31:0]      cr_state;
        logic [31:0]      db_ret;
        logic [31:0]      db_state;
        logic [31:0]      prefix;
        logic [31:0]      syndrome;
        logic             dbg_en;
        logic [15:0][31:0] vec_off;
        logic [3:0]       last_vec;
        pie_class_t       last_class;
        logic             redirect;
        logic [31:0]      redirect_addr;
        logic [31:0]      brev_mask;
    } pie_state_t;

endpackage

//--- testbench/pie_entry_asserts.sv
// Purpose: concurrent checks on the interrupt entry ports
// Assumes: one clock domain, reset async active high
// Notes:   bound into every pie_entry instance
`timescale 1ns/1ns
module pie_entry_chk #(
    parameter bit SHORT_INSN = 1'b0
) (
    input wire logic               clock,
    input wire logic               reset,
    input wire logic               hreadyout,
    input wire logic               hresp,
    input wire logic               crit_req_n,
    input wire logic               ext_req_n,
    input wire logic               mchk_req_n,
    input wire pie_pkg::pie_instr_t instr,
    input wire pie_pkg::pie_exc_t   exc,
    input wire logic               redirect,
    input wire logic [31:0]        redirect_addr,
    input wire logic               supervisor,
    input wire logic               busy,
    input wire logic [31:0]        brev_mask
);
    import pie_pkg::*;
    logic [2:0] quiet_q;
    logic       cause;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    // pins pass two sync stages, so quiet must outlast them
    assign cause = !crit_req_n || !ext_req_n || !mchk_req_n
                   || instr.valid || (|exc);
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            quiet_q <= 3'h0;
        end else if (cause) begin
            quiet_q <= 3'h0;
        end else if (quiet_q != 3'h7) begin
            quiet_q <= quiet_q + 3'h1;
        end
    end
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    bus_ready_a: assert property (!$past(reset) |-> hreadyout)
        else $error("hreadyout low after reset");
    mask_limit_a: assert property (!$past(reset) |-> brev_mask ==
        ($past(instr.brev_mask) & (SHORT_INSN ? 32'h0000_ffff : 32'hffff_ffff)))
        else $error("brev_mask wrong");
    quiet_hold_a: assert property (quiet_q >= 3'h6 |-> !busy && !redirect)
        else $error("take without cause");
    handler_super_a: assert property (busy |-> supervisor ##1 supervisor)
        else $error("handler not supervisor");
    take_order_a: assert property (busy |=> redirect && !busy)
        else $error("save not followed by fetch");
    redirect_pulse_a: assert property (redirect |=> !redirect)
        else $error("redirect longer than one cycle");
    addr_stands_a: assert property ((!redirect && !busy) |->
        $stable(redirect_addr))
        else $error("redirect_addr moved");
    vec_align_a: assert property (busy |=> redirect_addr[3:0] == 4'h0)
        else $error("vector low bits not zero");
endmodule
bind pie_entry pie_entry_chk #(.SHORT_INSN(SHORT_INSN)) u_pie_entry_chk (
    .clock(clock), .reset(reset), .hreadyout(hreadyout), .hresp(hresp),
    .crit_req_n(crit_req_n), .ext_req_n(ext_req_n), .mchk_req_n(mchk_req_n),
    .instr(instr), .exc(exc), .redirect(redirect),
    .redirect_addr(redirect_addr), .supervisor(supervisor), .busy(busy),
    .brev_mask(brev_mask)
);

//--- testbench/pie_irq_src.sv
// Purpose: far-side request pins feeding the entry block
// Assumes: requests are levels held until the bench releases them
// Notes:   pins change only just after a rising edge
`timescale 1ns/1ns
module pie_irq_src (
    input  wire logic clock,
    output logic      crit_req_n,
    output logic      ext_req_n,
    output logic      mchk_req_n
);
    initial begin
        {crit_req_n, ext_req_n, mchk_req_n} = 3'h7;
    end
    // a real source keeps asserting until software clears it
    task automatic drive(input logic [2:0] lv);
        @(posedge clock);
        {crit_req_n, ext_req_n, mchk_req_n} <= lv;
    endtask
endmodule

//--- testbench/tb_pie_entry.sv
// Purpose: self-checking bench for the interrupt entry block
// Assumes: zero-wait ahb slave, pins through the far-side model
// Notes:   expected redirects and reads queue up for the monitor
`timescale 1ns/1ns
`include "pie_params.svh"
module tb_pie_entry;
    import pie_pkg::*;
    logic        clock, reset, hwrite, hreadyout, rd_ph, hsel;
    logic [2:0]  hsize;
    logic        crit_req_n, ext_req_n, mchk_req_n;
    logic        redirect, supervisor, busy;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, redirect_addr, pfx, brev_mask;
    logic [31:0] red_q[$], rd_q[$], vec[16], p[4];
    pie_instr_t  instr;
    pie_exc_t    exc;
    int          failures, total_checks, cyc;
    pie_op_t     op_t[6] = '{PIE_OP_DC_OTHER, PIE_OP_DC_INVAL, PIE_OP_DC_INVAL,
                             PIE_OP_DC_ZERO, PIE_OP_DCR, PIE_OP_DCR};
    logic [9:0]  dn_t[6] = '{0, 0, 0, 0, 10'h03f, `PIE_DCR_COUNT};
    logic [3:0]  v_t[6] = '{0, `PIE_V_PROG, 0, `PIE_V_ALIGN, 0, `PIE_V_PROG};
    logic [31:0] sy_t[6] = '{0, 32'h1000_0000, 0, 32'h0080_0000, 0,
                             32'h0800_0000};
    pie_entry #(.SHORT_INSN(1'b1)) u_pie_entry (
        .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(), .crit_req_n(crit_req_n), .ext_req_n(ext_req_n),
        .mchk_req_n(mchk_req_n), .instr(instr), .exc(exc),
        .redirect(redirect), .redirect_addr(redirect_addr),
        .supervisor(supervisor), .busy(busy), .brev_mask(brev_mask));
    pie_irq_src u_pie_irq_src (.clock(clock), .crit_req_n(crit_req_n),
        .ext_req_n(ext_req_n), .mchk_req_n(mchk_req_n));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    function automatic logic [31:0] vaddr(input logic [3:0] v);
        return {pfx[31:16], vec[v][15:4], 4'h0};
    endfunction
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clock); while (hreadyout !== 1'b1);
        if (!w) rd_q.push_back(d);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
    endtask
    task automatic settle();
        for (int i = 0; i < 12 && red_q.size() != 0; i++) @(posedge clock);
        repeat (3) @(posedge clock);
        cmp("redirects left", 32'h0, 32'(red_q.size()));
    endtask
    task automatic chk_sup(input logic e);
        @(negedge clock);
        cmp("supervisor", {31'h0, e}, {31'h0, supervisor});
    endtask
    task automatic take(input logic [2:0] pins, input logic [3:0] v,
                        input logic [31:0] pc);
        @(posedge clock);
        instr.pc <= pc;
        red_q.push_back(vaddr(v));
        u_pie_irq_src.drive(pins);
        for (int i = 0; i < 12 && red_q.size() != 0; i++) @(posedge clock);
        u_pie_irq_src.drive(3'h7);
        settle();
    endtask
    task automatic pulse(input pie_exc_t ev, input logic [31:0] pc,
                         input logic [31:0] e);
        @(posedge clock);
        instr.pc <= pc;
        exc      <= ev;
        if (e != 32'h0) red_q.push_back(e);
        @(posedge clock);
        exc <= '0;
        settle();
    endtask
    task automatic issue(input pie_op_t op, input logic [9:0] dn,
                         input logic [31:0] e);
        logic [31:0] m;
        m = $urandom();
        @(posedge clock);
        instr <= '{1'b1, op, p[3], dn, m};
        if (e != 32'h0) red_q.push_back(e);
        @(posedge clock);
        instr.valid <= 1'b0;
        @(negedge clock);
        cmp("brev_mask", m & 32'h0000_ffff, brev_mask);
        settle();
    endtask
    always @(posedge clock) begin
        rd_ph <= !reset && htrans[1] && !hwrite;
        cyc++;
        if (cyc == 8000) begin
            failures++;
            give_verdict();
        end
    end
    always @(negedge clock) begin
        if (rd_ph) begin
            cmp("hrdata", rd_q.pop_front(), hrdata);
        end
        if (redirect === 1'b1 && red_q.size() == 0) begin
            cmp("unexpected redirect", 32'h0, 32'h1);
        end else if (redirect === 1'b1) begin
            cmp("redirect_addr", red_q.pop_front(), redirect_addr);
        end
    end
    initial begin
        {reset, rd_ph, hwrite, htrans, haddr, hwdata} = '1;
        {rd_ph, hwrite, htrans, haddr, hwdata} = '0;
        hsel = 1'b1;
        hsize = 3'h2;
        {instr, exc, failures, total_checks, cyc} = '0;
        void'($urandom(65428));
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        chk_sup(1'b1);
        ahb(1'b0, `PIE_A_MSTATE, 32'h0);
        ahb(1'b1, 8'h30, 32'hffff_ffff);
        ahb(1'b0, 8'h30, 32'h0);
        pfx = $urandom();
        ahb(1'b1, `PIE_A_PREFIX, pfx);
        hsel <= 1'b0;
        ahb(1'b1, `PIE_A_PREFIX, ~pfx);
        hsel <= 1'b1;
        ahb(1'b0, `PIE_A_PREFIX, pfx);
        for (int i = 0; i < 16; i++) begin
            vec[i] = $urandom();
            p[i % 4] = $urandom() & 32'hffff_fffc;
            ahb(1'b1, 8'(`PIE_A_VEC_BASE + 4 * i), vec[i]);
        end
        ahb(1'b0, 8'h7c, vec[15]);
        u_pie_irq_src.drive(3'b101);
        settle();
        u_pie_irq_src.drive(3'h7);
        ahb(1'b1, `PIE_A_MSTATE, 32'h0000_c000);
        chk_sup(1'b0);
        take(3'b101, `PIE_V_EXT, p[0]);
        ahb(1'b0, `PIE_A_NC_RET, p[0]);
        ahb(1'b0, `PIE_A_NC_STATE, 32'h0000_c000);
        ahb(1'b0, `PIE_A_MSTATE, 32'h0);
        ahb(1'b0, `PIE_A_STATUS, 32'h14);
        ahb(1'b1, `PIE_A_MSTATE, 32'h0002_0200);
        pulse(4'b0001, p[2], 32'h0);
        take(3'b011, `PIE_V_CRIT, p[1]);
        ahb(1'b0, `PIE_A_CR_RET, p[1]);
        ahb(1'b0, `PIE_A_CR_STATE, 32'h0002_0200);
        ahb(1'b0, `PIE_A_NC_RET, p[0]);
        ahb(1'b1, `PIE_A_CONFIG, 32'h1);
        pulse(4'b0001, p[2], vaddr(`PIE_V_DEBUG));
        ahb(1'b0, `PIE_A_DB_RET, p[2]);
        ahb(1'b0, `PIE_A_DB_STATE, 32'h0000_0200);
        issue(PIE_OP_RET_DB, 10'h0, p[2]);
        ahb(1'b0, `PIE_A_MSTATE, 32'h0000_0200);
        issue(PIE_OP_RET_CR, 10'h0, p[1]);
        issue(PIE_OP_RET_NC, 10'h0, p[0]);
        ahb(1'b0, `PIE_A_MSTATE, 32'h0000_c000);
        for (int i = 0; i < 6; i++) begin
            ahb(1'b1, `PIE_A_SYNDROME, 32'h0);
            issue(op_t[i], dn_t[i],
                  v_t[i] == 4'h0 ? 32'h0 : vaddr(v_t[i]));
            ahb(1'b0, `PIE_A_SYNDROME, sy_t[i]);
        end
        ahb(1'b0, `PIE_A_STATUS, 32'h16);
        ahb(1'b1, `PIE_A_SYNDROME, 32'h0);
        pulse(4'b1100, p[1], vaddr(`PIE_V_DSTORE));
        ahb(1'b0, `PIE_A_SYNDROME, 32'h0080_0000);
        pulse(4'b0010, p[0], vaddr(`PIE_V_ISTORE));
        ahb(1'b0, `PIE_A_SYNDROME, 32'h0080_0000);
        ahb(1'b0, `PIE_A_NC_RET, p[0]);
        ahb(1'b1, `PIE_A_MSTATE, 32'h0002_9000);
        take(3'b000, `PIE_V_CRIT, p[3]);
        ahb(1'b0, `PIE_A_MSTATE, 32'h0);
        ahb(1'b1, `PIE_A_MSTATE, 32'h0000_1000);
        take(3'b110, `PIE_V_MCHK, p[2]);
        ahb(1'b0, `PIE_A_CR_RET, p[2]);
        give_verdict();
    end
endmodule
